//--- logic/psra_defs.svh
// constants for the pressure sensor ready and alert block
// assumes a 40 MHz system clock; times are kept in microseconds
`ifndef PSRA_DEFS_SVH
`define PSRA_DEFS_SVH

// ****************************************
// clock and timing
// ****************************************
`define PSRA_CLK_KHZ 40000
`define PSRA_PU_TIME_US 25000
`define PSRA_SR_TIME_US 20000
`define PSRA_PD_PERIOD_US 500
// all three times round down to whole cycles
`define PSRA_PU_CYCLES ((`PSRA_PU_TIME_US * `PSRA_CLK_KHZ) / 1000)
`define PSRA_SR_CYCLES ((`PSRA_SR_TIME_US * `PSRA_CLK_KHZ) / 1000)
`define PSRA_PD_CYCLES ((`PSRA_PD_PERIOD_US * `PSRA_CLK_KHZ) / 1000)
`define PSRA_TEMP_EVERY 16

// ****************************************
// bus address strap
// ****************************************
`define PSRA_STRAP_GND 2'h0
`define PSRA_STRAP_1K2 2'h1
`define PSRA_STRAP_2K7 2'h2
`define PSRA_ADDR_GND 7'h21
`define PSRA_ADDR_1K2 7'h22
`define PSRA_ADDR_2K7 7'h23

`endif

//--- logic/psra_pkg.sv
// types for the pressure sensor ready and alert block
// assumes nothing beyond the constants header
package psra_pkg;
  typedef logic [6:0] psra_addr_t;
  typedef logic [1:0] psra_strap_t;
  // gray along wait -> idle -> measure
  typedef enum logic [1:0] {
    PSRA_ST_WAIT = 2'b00,
    PSRA_ST_IDLE = 2'b01,
    PSRA_ST_MEAS = 2'b11
  } psra_state_t;
endpackage

//--- logic/psra_tick_if.sv
// carrier between the sequencer and the result-rate divider
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface psra_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport use_end (output run, input tick);
endinterface

//--- logic/psra_tick_gen.sv
// result-rate divider: one-cycle tick per measurement period
// assumes run comes from logic on sys_clk
`timescale 1ns/1ps
module psra_tick_gen #(
  parameter int PERIOD = 20000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  psra_tick_if.gen tk
);
  import psra_pkg::*;

  if (PERIOD < 2 || PERIOD > 65535) begin : g_chk
    $error("psra_tick_gen: PERIOD out of range");
  end

  logic [15:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // ****************************************
  // divider
  // ****************************************
  // restarts while stopped so the first result is one period after start
  always_comb begin
    cnt_d = 16'h0000;
    tick_d = 1'b0;
    if (tk.run) begin
      if (cnt_q == 16'(PERIOD - 1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // registers only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule

//--- logic/psra_core.sv
// ready sequencing, address strap and new-data alert of the sensor
// assumes the command decoder and bus front end run on sys_clk and
// give one-cycle pulses; the strap code arrives from a pin comparator
`timescale 1ns/1ps
`include "psra_defs.svh"

// Operation
// - after power-on reset, ready rises within 25 ms
// - after soft reset, ready rises within 20 ms; commands wait for it
// - continuous mode refreshes pressure at 2000 Hz, within 1800 to 2200
// - temperature refreshes at least once per 16 pressure updates
// - strap selects bus address 0x21, 0x22 or 0x23
// - alert low means an unread result exists or no start since the last reset, high otherwise
// - alert returns high once a pressure value is read; the core does this only in measure state, a read after stop leaves it low
// - after any reset alert stays low until a measurement command
// - continuous mode makes a result every 0.5 ms and pulls alert low
module psra_core #(
  parameter int PU_CYCLES = `PSRA_PU_CYCLES,
  parameter int SR_CYCLES = `PSRA_SR_CYCLES,
  parameter int PD_CYCLES = `PSRA_PD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_reset_cmd,
  input wire logic meas_start_cmd,
  input wire logic meas_stop_cmd,
  input wire logic pd_read_done,
  input wire psra_pkg::psra_strap_t addr_strap,
  output logic new_data_alert_n,
  output logic ready,
  output logic measuring,
  output psra_pkg::psra_addr_t bus_addr,
  output logic pd_update,
  output logic temp_update
);
  import psra_pkg::*;

  if (PU_CYCLES < 1 || PU_CYCLES > 16777215 ||
      SR_CYCLES < 1 || SR_CYCLES > 16777215) begin : g_chk
    $error("psra_core: ready time out of range");
  end

  // strap code to bus address; an illegal code falls back to ground
  function automatic psra_addr_t strap_addr(input psra_strap_t s);
    case (s)
      `PSRA_STRAP_1K2: strap_addr = `PSRA_ADDR_1K2;
      `PSRA_STRAP_2K7: strap_addr = `PSRA_ADDR_2K7;
      default: strap_addr = `PSRA_ADDR_GND;
    endcase
  endfunction

  // ****************************************
  // strap synchroniser
  // ****************************************
  psra_strap_t strap_m_q, strap_s_q;
  always_ff @(posedge sys_clk) begin
    strap_m_q <= addr_strap;
    strap_s_q <= strap_m_q;
  end

  // ****************************************
  // result-rate divider
  // ****************************************
  psra_tick_if tk ();
  psra_tick_gen #(.PERIOD(PD_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tk(tk)
  );

  // ****************************************
  // sequencer
  // ****************************************
  psra_state_t state_q, state_d;
  logic [23:0] cnt_q, cnt_d;
  logic [23:0] lim_q, lim_d;
  logic alert_n_q, alert_n_d;
  logic ready_q, ready_d;
  psra_addr_t addr_q, addr_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic pd_upd_q, pd_upd_d;
  logic tmp_upd_q, tmp_upd_d;
  logic meas_q, meas_d;

  assign tk.run = (state_q == PSRA_ST_MEAS);

  // next values; a result in the same cycle as a read keeps alert low
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    lim_d = lim_q;
    alert_n_d = alert_n_q;
    ready_d = ready_q;
    addr_d = addr_q;
    tcnt_d = tcnt_q;
    pd_upd_d = 1'b0;
    tmp_upd_d = 1'b0;
    case (state_q)
      PSRA_ST_WAIT: begin
        alert_n_d = 1'b0;
        if (cnt_q == lim_q - 24'h00_0001) begin
          state_d = PSRA_ST_IDLE;
          ready_d = 1'b1;
          addr_d = strap_addr(strap_s_q);
        end else begin
          cnt_d = cnt_q + 24'h00_0001;
        end
      end
      PSRA_ST_IDLE: begin
        if (meas_start_cmd) begin
          state_d = PSRA_ST_MEAS;
          alert_n_d = 1'b1;
          tcnt_d = 4'h0;
        end
      end
      PSRA_ST_MEAS: begin
        if (pd_read_done) begin
          alert_n_d = 1'b1;
        end
        if (tk.tick) begin
          alert_n_d = 1'b0;
          pd_upd_d = 1'b1;
          tcnt_d = tcnt_q + 4'h1;
          tmp_upd_d = (tcnt_q == 4'(`PSRA_TEMP_EVERY - 1));
        end
        if (meas_stop_cmd) begin
          state_d = PSRA_ST_IDLE;
        end
      end
      default: begin
        state_d = PSRA_ST_WAIT;
        cnt_d = 24'h00_0000;
      end
    endcase
    // soft reset is honoured only once ready
    if (soft_reset_cmd && state_q != PSRA_ST_WAIT) begin
      state_d = PSRA_ST_WAIT;
      cnt_d = 24'h00_0000;
      lim_d = 24'(SR_CYCLES);
      alert_n_d = 1'b0;
      ready_d = 1'b0;
      pd_upd_d = 1'b0;
      tmp_upd_d = 1'b0;
    end
    // mode flag registered so the output leaves a flop
    meas_d = (state_d == PSRA_ST_MEAS);
  end

  // registers only; power-on wait uses the longer limit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= PSRA_ST_WAIT;
      cnt_q <= 24'h00_0000;
      lim_q <= 24'(PU_CYCLES);
      alert_n_q <= 1'b0;
      ready_q <= 1'b0;
      addr_q <= `PSRA_ADDR_GND;
      tcnt_q <= 4'h0;
      pd_upd_q <= 1'b0;
      tmp_upd_q <= 1'b0;
      meas_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      lim_q <= lim_d;
      alert_n_q <= alert_n_d;
      ready_q <= ready_d;
      addr_q <= addr_d;
      tcnt_q <= tcnt_d;
      pd_upd_q <= pd_upd_d;
      tmp_upd_q <= tmp_upd_d;
      meas_q <= meas_d;
    end
  end

  // all outputs straight from flops
  assign new_data_alert_n = alert_n_q;
  assign ready = ready_q;
  assign measuring = meas_q;
  assign bus_addr = addr_q;
  assign pd_update = pd_upd_q;
  assign temp_update = tmp_upd_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // cycles since last pressure update and pressure updates since last temperature update, for rate checks
  logic [15:0] gap_q;
  logic [4:0] since_t_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_q != PSRA_ST_MEAS) begin
      gap_q <= 16'h0000;
      since_t_q <= 5'h00;
    end else begin
      // stays zero until the first result, so start latency is not timed
      if (pd_upd_q) gap_q <= 16'h0001;
      else if (gap_q != 16'h0000) gap_q <= gap_q + 16'h0001;
      if (tmp_upd_q) since_t_q <= 5'h00;
      else if (pd_upd_q) since_t_q <= since_t_q + 5'h01;
    end
  end

  // set once a start is taken, cleared by either kind of reset
  logic cmd_seen_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (soft_reset_cmd && ready_q)) begin
      cmd_seen_q <= 1'b0;
    end else if (meas_start_cmd && state_q == PSRA_ST_IDLE) begin
      cmd_seen_q <= 1'b1;
    end
  end

  sequence s_result;
    tk.tick && state_q == PSRA_ST_MEAS && !soft_reset_cmd;
  endsequence
  sequence s_read_only;
    state_q == PSRA_ST_MEAS && pd_read_done && !tk.tick && !soft_reset_cmd;
  endsequence

  AST_WAIT_COUNT_BOUND: assert property (
    state_q == PSRA_ST_WAIT |-> cnt_q < lim_q)
    else $error("ready wait overran its limit");
  AST_SOFT_RESET_WAIT: assert property (
    soft_reset_cmd && ready_q |=> !ready_q && lim_q == 24'(SR_CYCLES))
    else $error("soft reset did not restart the ready wait");
  AST_PD_PERIOD: assert property (
    pd_upd_q && gap_q != 16'h0000 |-> gap_q == 16'(PD_CYCLES))
    else $error("pressure update period wrong");
  AST_TEMP_EVERY: assert property (
    since_t_q < 5'd16 && (!tmp_upd_q || pd_upd_q))
    else $error("temperature update missed");
  AST_ADDR_LEGAL: assert property (
    ready_q |-> bus_addr inside {7'h21, 7'h22, 7'h23})
    else $error("illegal bus address");
  AST_RESULT_ALERT: assert property (
    s_result |=> !new_data_alert_n ##1 pd_update == 1'b0)
    else $error("result did not pull alert low");
  AST_READ_RELEASE: assert property (
    s_read_only |=> new_data_alert_n)
    else $error("read did not release alert");
  AST_RESET_ALERT: assert property (
    !cmd_seen_q |-> !new_data_alert_n)
    else $error("alert high before measurement command");
  AST_TICK_PULSE: assert property (
    pd_update |=> !pd_update)
    else $error("result pulse not single");
  AST_ADDR_HOLD: assert property (
    state_q != PSRA_ST_WAIT && $past(state_q) != PSRA_ST_WAIT
      |-> $stable(bus_addr))
    else $error("bus address changed outside reset");
endmodule

//--- tb/psra_ctrl_model.sv
// bus controller model that reads pressure results on request
// assumes sys_clk from the bench; drives at the falling edge
`timescale 1ns/1ps
module psra_ctrl_model (
  input wire logic sys_clk,
  input wire logic ready,
  input wire logic new_data_alert_n,
  input wire logic rd_req,
  output logic pd_read_done
);
  // ****************************************
  // read request capture and read pulse
  // ****************************************
  logic rd_q;

  initial begin
    rd_q = 1'b0;
    pd_read_done = 1'b0;
  end

  // request sampled on the rising edge to avoid racing the bench
  always @(posedge sys_clk) begin
    rd_q <= rd_req;
  end

  // one-cycle read, only while ready and a result is pending
  always @(negedge sys_clk) begin
    pd_read_done <= rd_q && ready && !new_data_alert_n && !pd_read_done;
  end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the ready, strap and alert core
// assumes shortened wait counts; inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
  import psra_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam int PU = 40;
  localparam int SR = 30;
  localparam int PD = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset_cmd = 1'b0;
  logic meas_start_cmd = 1'b0;
  logic meas_stop_cmd = 1'b0;
  logic rd_req = 1'b0;
  logic pd_read_done;
  psra_strap_t addr_strap = 2'h0;
  logic new_data_alert_n, ready, measuring, pd_update, temp_update;
  psra_addr_t bus_addr;
  psra_addr_t held;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n, k, last_pd;

  always #12.5 sys_clk = ~sys_clk;

  psra_core #(.PU_CYCLES(PU), .SR_CYCLES(SR), .PD_CYCLES(PD)) psra_core_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .soft_reset_cmd(soft_reset_cmd),
    .meas_start_cmd(meas_start_cmd), .meas_stop_cmd(meas_stop_cmd),
    .pd_read_done(pd_read_done), .addr_strap(addr_strap),
    .new_data_alert_n(new_data_alert_n), .ready(ready),
    .measuring(measuring), .bus_addr(bus_addr), .pd_update(pd_update),
    .temp_update(temp_update));

  psra_ctrl_model psra_ctrl_model_i (
    .sys_clk(sys_clk), .ready(ready), .new_data_alert_n(new_data_alert_n),
    .rd_req(rd_req), .pd_read_done(pd_read_done));

  // ****************************************
  // helpers
  // ****************************************
  function automatic psra_addr_t addr_of(psra_strap_t s);
    case (s)
      2'h1: return 7'h22;
      2'h2: return 7'h23;
      default: return 7'h21; // illegal code falls back to ground address
    endcase
  endfunction

  task automatic check(string what, logic [6:0] seen, logic [6:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // command pulse: 0 soft reset, 1 start, 2 stop
  task automatic cmd(int w);
    @(negedge sys_clk);
    soft_reset_cmd = (w == 0);
    meas_start_cmd = (w == 1);
    meas_stop_cmd = (w == 2);
    @(negedge sys_clk);
    {soft_reset_cmd, meas_start_cmd, meas_stop_cmd} = 3'h0;
  endtask

  // bounded wait for a level or pulse, counting falling edges in n
  task automatic wait_for(ref logic sig, input int lim);
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic do_reset(psra_strap_t s);
    @(negedge sys_clk);
    addr_strap = s;
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check("alert_in_reset", new_data_alert_n, 1'b0);
    check("ready_in_reset", ready, 1'b0);
    rst_n = 1'b1;
    wait_for(ready, PU + 10);
    check("pu_delay", n >= PU - 1 && n <= PU + 2, 1'b1);
    check("bus_addr", bus_addr, addr_of(s));
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(16));
    // every strap code, then random ones; strap moves after ready
    for (k = 0; k < 6; k++) begin
      do_reset(k < 4 ? psra_strap_t'(k) : psra_strap_t'($urandom % 4));
      held = bus_addr;
      addr_strap = ~addr_strap;
      repeat (5) @(negedge sys_clk);
      check("addr_held", bus_addr, held);
    end
    repeat (10) @(negedge sys_clk);
    check("alert_before_start", new_data_alert_n, 1'b0);
    cmd(1);
    check("measuring", measuring, 1'b1);
    check("alert_cleared", new_data_alert_n, 1'b1);
    last_pd = cyc;
    // results, temperature cadence, random reads
    for (k = 1; k <= 33; k++) begin
      wait_for(pd_update, PD + 5);
      // first result one period plus the registering cycle after start
      check("pd_period", cyc - last_pd, k == 1 ? PD + 1 : PD);
      last_pd = cyc;
      check("alert_on_result", new_data_alert_n, 1'b0);
      check("temp_update", temp_update, (k % 16) == 0);
      @(negedge sys_clk);
      if ($urandom % 2) begin
        rd_req = 1'b1;
        @(negedge sys_clk);
        rd_req = 1'b0;
        @(negedge sys_clk);
        check("alert_after_read", new_data_alert_n, 1'b1);
      end
    end
    cmd(2);
    check("stopped", measuring, 1'b0);
    // soft reset, with a start refused while not ready
    cmd(0);
    check("sr_ready", ready, 1'b0);
    check("sr_alert", new_data_alert_n, 1'b0);
    cmd(1);
    check("start_refused", measuring, 1'b0);
    wait_for(ready, SR + 10);
    check("sr_delay", n + 2 >= SR - 1 && n + 2 <= SR + 2, 1'b1);
    check("sr_alert_held", new_data_alert_n, 1'b0);
    finish_test();
  end
endmodule
